/* hdl/dsc_pkg.sv */
package dsc_pkg;

  // channel and reference counts
  localparam int NUM_DPLL = 2;
  localparam int NUM_REF = 4;
  localparam int REF_W = 2;
  localparam int PRIO_W = 3;
  localparam int TRIG_W = 4;

  // failure trigger bit positions, shared by both trigger masks
  localparam int TRIG_LOS = 0;
  localparam int TRIG_SCM = 1;
  localparam int TRIG_CFM = 2;
  localparam int TRIG_GST = 3;

  // priority code that removes a reference from automatic selection
  localparam logic [PRIO_W-1:0] PRIO_EXCLUDE = 3'h7;

  // reset values of the per-channel configuration
  localparam logic [TRIG_W-1:0] SW_MASK_RST = 4'h8;
  localparam logic [TRIG_W-1:0] HO_MASK_RST = 4'h7;
  localparam logic [NUM_REF*PRIO_W-1:0] PRIO_RST = {3'h3, 3'h2, 3'h1, 3'h0};
  localparam logic HITLESS_RST = 1'h1;

  // gray coded along freerun -> normal -> holdover -> normal
  typedef enum logic [1:0] {
    ST_FREERUN = 2'h0,
    ST_NORMAL = 2'h1,
    ST_HOLDOVER = 2'h3
  } dsc_state_t;

  // failure indicators of one reference, bit order as the trigger masks
  typedef struct packed {
    logic gst;
    logic coarse_frequency_check_fail;
    logic single_period_check_fail;
    logic los;
  } dsc_fail_t;

  typedef struct packed {
    logic hitless;
    logic [TRIG_W-1:0] switch_trigger_mask;
    logic [TRIG_W-1:0] holdover_trigger_mask;
    logic [NUM_REF*PRIO_W-1:0] prio;
  } dsc_cfg_t;

  localparam dsc_cfg_t CFG_RST = '{
    hitless: HITLESS_RST,
    switch_trigger_mask: SW_MASK_RST,
    holdover_trigger_mask: HO_MASK_RST,
    prio: PRIO_RST
  };

  typedef struct packed {
    logic managed;
    logic [1:0] state_req;
    logic [REF_W-1:0] ref_req;
  } dsc_ctrl_t;

  typedef struct packed {
    logic [1:0] state;
    logic normal;
    logic holdover;
    logic [REF_W-1:0] ref_used;
    logic [2:0] ref_mon;
    logic locked;
    logic hitless;
  } dsc_status_t;

endpackage

/* hdl/dsc_state_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none

module dsc_state_ctrl
  import dsc_pkg::*;
#(
  parameter int N_DPLL = NUM_DPLL
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // reference monitor indicators, shared by all channels
  input wire dsc_fail_t [NUM_REF-1:0] I_REF_FAIL,
  // per-channel configuration, captured on its write strobe
  input wire logic [N_DPLL-1:0] I_CFG_WR,
  input wire dsc_cfg_t [N_DPLL-1:0] I_CFG,
  // per-channel control bits
  input wire dsc_ctrl_t [N_DPLL-1:0] I_CTRL,
  // phase lock indication from each DPLL core
  input wire logic [N_DPLL-1:0] I_PHASE_LOCKED,
  // per-channel status
  output dsc_status_t [N_DPLL-1:0] O_STATUS
);

  // best available reference: lowest priority value, ties to lower index
  function automatic logic [REF_W:0] pick_best(
    input logic [NUM_REF-1:0] avail,
    input logic [NUM_REF*PRIO_W-1:0] prio
  );
    logic found;
    logic [REF_W-1:0] idx;
    logic [PRIO_W-1:0] best_p;
    found = 1'b0;
    idx = '0;
    best_p = PRIO_EXCLUDE;
    for (int r = 0; r < NUM_REF; r++) begin
      // strict compare keeps the earlier, lower-numbered reference on a tie
      if (avail[r] && (!found || prio[r*PRIO_W +: PRIO_W] < best_p)) begin
        found = 1'b1;
        idx = REF_W'(r);
        best_p = prio[r*PRIO_W +: PRIO_W];
      end
    end
    return {found, idx};
  endfunction

  function automatic logic [PRIO_W-1:0] prio_of(
    input logic [NUM_REF*PRIO_W-1:0] prio,
    input logic [REF_W-1:0] idx
  );
    return prio[idx*PRIO_W +: PRIO_W];
  endfunction

  // a reference is valid while none of its monitors flags a failure
  logic [NUM_REF-1:0] ref_valid;

  always_comb begin
    for (int r = 0; r < NUM_REF; r++) begin
      ref_valid[r] = ~|I_REF_FAIL[r];
    end
  end

  genvar g;
  generate
    for (g = 0; g < N_DPLL; g++) begin : g_dpll
      // nothing below is shared between channels
      dsc_cfg_t cfg_reg;
      dsc_state_t state_reg;
      dsc_state_t state_next;
      logic [REF_W-1:0] ref_reg;
      logic [REF_W-1:0] ref_next;
      logic managed_reg;
      dsc_status_t status_reg;
      logic [NUM_REF-1:0] ref_avail;
      logic [REF_W:0] best;
      logic best_found;
      logic [REF_W-1:0] best_idx;
      logic [TRIG_W-1:0] cur_fail;
      logic switch_cond;
      logic holdover_cond;
      logic cur_valid;
      logic best_higher;

      // configuration holds its documented defaults until software writes it
      always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
          cfg_reg <= CFG_RST;
        end else if (I_CFG_WR[g]) begin
          cfg_reg <= I_CFG[g];
        end
      end

      always_comb begin
        for (int r = 0; r < NUM_REF; r++) begin
          ref_avail[r] = ref_valid[r] && (prio_of(cfg_reg.prio, REF_W'(r)) != PRIO_EXCLUDE);
        end
      end

      assign best = pick_best(ref_avail, cfg_reg.prio);
      assign best_found = best[REF_W];
      assign best_idx = best[REF_W-1:0];
      assign cur_fail = I_REF_FAIL[ref_reg];
      assign cur_valid = ref_valid[ref_reg];
      assign switch_cond = |(cur_fail & cfg_reg.switch_trigger_mask);
      assign holdover_cond = |(cur_fail & cfg_reg.holdover_trigger_mask);
      // only a strictly better priority pulls the selection back
      assign best_higher = best_found && (best_idx != ref_reg) &&
                           (prio_of(cfg_reg.prio, best_idx) < prio_of(cfg_reg.prio, ref_reg));

      always_comb begin
        state_next = state_reg;
        ref_next = ref_reg;
        if (I_CTRL[g].managed) begin
          if (I_CTRL[g].ref_req != ref_reg) begin
            // new selection always passes through holdover first
            ref_next = I_CTRL[g].ref_req;
            state_next = ST_HOLDOVER;
          end else begin
            case (I_CTRL[g].state_req)
              ST_FREERUN: begin
                state_next = ST_FREERUN;
              end
              ST_HOLDOVER: begin
                state_next = ST_HOLDOVER;
              end
              default: begin
                // normal requested: auto-holdover while the chosen input is bad
                if (holdover_cond || !cur_valid) begin
                  state_next = ST_HOLDOVER;
                end else begin
                  state_next = ST_NORMAL;
                end
              end
            endcase
          end
        end else begin
          // leaving managed mode keeps ref_reg; only conditions move it
          case (state_reg)
            ST_FREERUN: begin
              if (best_found) begin
                ref_next = best_idx;
                state_next = ST_NORMAL;
              end
            end
            ST_NORMAL, ST_HOLDOVER: begin
              if (switch_cond) begin
                if (best_found && best_idx != ref_reg) begin
                  ref_next = best_idx;
                  state_next = ST_NORMAL;
                end else begin
                  state_next = ST_HOLDOVER;
                end
              end else if (best_higher) begin
                ref_next = best_idx;
                state_next = ST_NORMAL;
              end else if (holdover_cond) begin
                state_next = ST_HOLDOVER;
              end else begin
                state_next = ST_NORMAL;
              end
            end
            default: begin
              state_next = ST_FREERUN;
            end
          endcase
        end
      end

      always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
          state_reg <= ST_FREERUN;
          ref_reg <= '0;
        end else begin
          state_reg <= state_next;
          ref_reg <= ref_next;
        end
      end

      // mode is registered but feeds no status field or output; decisions use the live bit
      always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
          managed_reg <= 1'b0;
        end else begin
          managed_reg <= I_CTRL[g].managed;
        end
      end

      // status is built from the next state so it lines up with state_reg
      always_ff @(posedge I_CLOCK) begin
        if (I_RESET) begin
          status_reg <= '0;
          status_reg.state <= ST_FREERUN;
          status_reg.hitless <= HITLESS_RST;
        end else begin
          status_reg.state <= state_next;
          status_reg.normal <= (state_next == ST_NORMAL);
          status_reg.holdover <= (state_next == ST_HOLDOVER);
          status_reg.ref_used <= ref_next;
          status_reg.ref_mon <= {I_REF_FAIL[ref_next].coarse_frequency_check_fail,
                                 I_REF_FAIL[ref_next].single_period_check_fail,
                                 I_REF_FAIL[ref_next].los};
          // lock only counts while the loop is actually tracking
          status_reg.locked <= (state_next == ST_NORMAL) && I_PHASE_LOCKED[g];
          status_reg.hitless <= cfg_reg.hitless;
        end
      end

      assign O_STATUS[g] = status_reg;
    end
  endgenerate

endmodule

`default_nettype wire

/* dv/dsc_state_ctrl_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module dsc_state_ctrl_monitor
  import dsc_pkg::*;
#(
  parameter int N_DPLL = NUM_DPLL
) (
  // clock and reset
  input wire logic I_CLOCK,
  input wire logic I_RESET,
  // watched ports
  input wire dsc_fail_t [NUM_REF-1:0] I_REF_FAIL,
  input wire logic [N_DPLL-1:0] I_CFG_WR,
  input wire dsc_cfg_t [N_DPLL-1:0] I_CFG,
  input wire dsc_ctrl_t [N_DPLL-1:0] I_CTRL,
  input wire logic [N_DPLL-1:0] I_PHASE_LOCKED,
  input wire dsc_status_t [N_DPLL-1:0] O_STATUS
);
  // reset, flags and un-managed checks watch channel 0, managed checks the last channel
  wire dsc_status_t s = O_STATUS[0];
  wire dsc_status_t m = O_STATUS[N_DPLL-1];
  wire dsc_ctrl_t c = I_CTRL[N_DPLL-1];
  wire logic same = c.managed && c.ref_req == m.ref_used;
  wire logic bad = |I_REF_FAIL[0] && |I_REF_FAIL[1] && |I_REF_FAIL[2] && |I_REF_FAIL[3];
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  reset_start_a: assert property (disable iff (1'b0) I_RESET |=> s.state == ST_FREERUN)
    else $error("state not freerun after reset");
  select_switch_a: assert property (c.managed && !same |=> m.state == ST_HOLDOVER)
    else $error("select change did not pass holdover");
  select_follow_a: assert property (c.managed |=> m.ref_used == $past(c.ref_req))
    else $error("used reference differs from request");
  managed_keep_a: assert property (same |=> $stable(m.ref_used))
    else $error("reference moved in managed mode");
  managed_freerun_a: assert property (same && c.state_req == 2'h0 |=> m.state == ST_FREERUN)
    else $error("requested freerun not taken");
  forced_hold_a: assert property (same && c.state_req == 2'h3 |=> m.holdover)
    else $error("requested holdover not taken");
  failed_select_a: assert property (same && c.state_req != 2'h0 && |I_REF_FAIL[c.ref_req]
    |=> m.state == ST_HOLDOVER)
    else $error("failed reference left holdover");
  freerun_stay_a: assert property (!I_CTRL[0].managed && s.state == ST_FREERUN && bad
    |=> s.state == ST_FREERUN)
    else $error("left freerun without a reference");
  normal_flag_a: assert property (s.normal == (s.state == ST_NORMAL))
    else $error("normal flag wrong");
  holdover_flag_a: assert property (s.holdover == (s.state == ST_HOLDOVER))
    else $error("holdover flag wrong");
  lock_flag_a: assert property (##1 s.locked == (s.normal && $past(I_PHASE_LOCKED[0])))
    else $error("lock flag wrong");
endmodule
bind dsc_state_ctrl dsc_state_ctrl_monitor #(.N_DPLL(N_DPLL)) u_mon (.I_CLOCK(I_CLOCK),
  .I_RESET(I_RESET), .I_REF_FAIL(I_REF_FAIL), .I_CFG_WR(I_CFG_WR), .I_CFG(I_CFG),
  .I_CTRL(I_CTRL), .I_PHASE_LOCKED(I_PHASE_LOCKED), .O_STATUS(O_STATUS));
`default_nettype wire

/* dv/dsc_ctl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module dsc_ctl_model
  import dsc_pkg::*;
(
  input wire logic i_clock,
  input wire dsc_ctrl_t [NUM_DPLL-1:0] i_cmd,
  output dsc_ctrl_t [NUM_DPLL-1:0] o_ctrl
);
  // the controller moves its bits only off the device's sampling edge
  always_ff @(negedge i_clock) begin
    o_ctrl <= i_cmd;
  end
endmodule
`default_nettype wire

/* dv/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
  import dsc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  dsc_fail_t [NUM_REF-1:0] fail = 16'h1111;
  logic [1:0] wr = 2'h0;
  dsc_cfg_t [1:0] cfg = {CFG_RST, CFG_RST};
  dsc_ctrl_t [1:0] cmd = {5'h14, 5'h00};
  dsc_ctrl_t [1:0] ctrl;
  logic [1:0] plock = 2'h3;
  dsc_status_t [1:0] st;
  int fails = 0;
  int checks_done = 0;
  always #4 clk = ~clk;
  dsc_ctl_model u_ctl (.i_clock(clk), .i_cmd(cmd), .o_ctrl(ctrl));
  dsc_state_ctrl #(.N_DPLL(2)) u_dut (.I_CLOCK(clk), .I_RESET(rst), .I_REF_FAIL(fail),
    .I_CFG_WR(wr), .I_CFG(cfg), .I_CTRL(ctrl), .I_PHASE_LOCKED(plock), .O_STATUS(st));
  task automatic tick(input int n = 1);
    repeat (n) @(negedge clk);
  endtask
  task automatic cmp(input logic [5:0] got, input logic [5:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk(input int ch, input logic [1:0] s, input logic [1:0] r);
    cmp({st[ch].state, st[ch].normal, st[ch].holdover, st[ch].ref_used},
      {s, s == 2'h1, s == 2'h3, r});
  endtask
  task automatic ev(input int ch, input logic [1:0] s, input logic [1:0] r);
    tick();
    chk(ch, s, r);
  endtask
  // control bits pass the partner, which adds one cycle before the device sees them
  task automatic ctl(input dsc_ctrl_t v);
    cmd[1] <= v;
    tick();
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    logic [1:0] codes [3];
    codes = '{2'h0, 2'h3, 2'h1};
    tick(20);
    chk(0, 2'h0, 2'h0);
    rst = 1'b0;
    ev(0, 2'h0, 2'h0);
    chk(1, 2'h3, 2'h0);
    fail = '0;
    ev(0, 2'h1, 2'h0);
    chk(1, 2'h1, 2'h0);
    $display("test start done");
    fail[0].los = 1'b1;
    ev(0, 2'h3, 2'h0);
    cmp({3'h0, st[0].ref_mon}, 6'h1);
    fail = '0;
    ev(0, 2'h1, 2'h0);
    fail[0].gst = 1'b1;
    ev(0, 2'h1, 2'h1);
    fail = '0;
    ev(0, 2'h1, 2'h0);
    $display("test unmanaged done");
    cfg[0] = '{1'b0, 4'h8, 4'h7, {3'h2, 3'h2, 3'h2, 3'h7}};
    wr = 2'h1;
    tick();
    wr = 2'h0;
    ev(0, 2'h1, 2'h1);
    cmp({5'h0, st[0].hitless}, 6'h0);
    fail[1].gst = 1'b1;
    ev(0, 2'h1, 2'h2);
    fail = '0;
    ev(0, 2'h1, 2'h2);
    cmp({5'h0, st[0].locked}, 6'h1);
    plock[0] = 1'b0;
    ev(0, 2'h1, 2'h2);
    cmp({5'h0, st[0].locked}, 6'h0);
    plock = 2'h3;
    fail = 16'h8888;
    ev(0, 2'h3, 2'h2);
    fail = '0;
    ev(0, 2'h1, 2'h2);
    $display("test priority done");
    ctl(5'h16);
    ev(1, 2'h3, 2'h2);
    chk(0, 2'h1, 2'h2);
    ev(1, 2'h1, 2'h2);
    for (int i = 0; i < 3; i++) begin
      ctl({1'b1, codes[i], 2'h2});
      ev(1, codes[i], 2'h2);
    end
    fail[3].los = 1'b1;
    ctl(5'h17);
    ev(1, 2'h3, 2'h3);
    ev(1, 2'h3, 2'h3);
    fail = '0;
    ev(1, 2'h1, 2'h3);
    ctl(5'h14);
    ev(1, 2'h3, 2'h0);
    ctl(5'h04);
    ev(1, 2'h1, 2'h0);
    $display("test managed done");
    results();
  end
endmodule
`default_nettype wire
